// ### hw/fsp_consts.svh
// Operation
// - Erase whole array or one sector; program exactly one byte per operation.
// - A sector erase or program touches no byte outside its own sector.
// - Tool socket and in-circuit modes may program or erase every sector and options.
// - In-application mode refuses any change to sector 0; other sectors allowed.
// - 4K part has sector 0; 8K adds sector 1; larger adds sector 2.
// - Sectors 0 and 1 are 4 Kbytes; sector 0 sits at F000h-FFFFh.
// - With read-out protection on, no external path returns program memory contents.
// - Removing read-out protection first erases the whole array, then allows programming.
// - Flash parts switch protection by an option bit; mask parts fix it at build.
// - Link has one serial clock and one shared data line driven in turns.
// - Flash program control/status register governs program/erase and resets to zero; its protect bit resets to PROTECT_DEFAULT instead.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ****************************************
// Register byte offsets on the APB
// ****************************************
`define FSP_OFF_CSR 12'h038
`define FSP_OFF_ADDR 12'h03c
`define FSP_OFF_WDATA 12'h040
`define FSP_OFF_RDATA 12'h044
`define FSP_OFF_OPT 12'h048

// ****************************************
// Control/status field positions and reset
// ****************************************
`define FSP_CSR_PROG 0
`define FSP_CSR_SERASE 1
`define FSP_CSR_MERASE 2
`define FSP_CSR_BUSY 3
`define FSP_CSR_REFUSED 4
`define FSP_CSR_PROTECT 5
`define FSP_CSR_RESET 8'h00

// ****************************************
// Sector layout and array values
// ****************************************
`define FSP_SECT0_START 16'hf000
`define FSP_SECT0_END 16'hffff
`define FSP_SECT1_START 16'he000
`define FSP_SECT1_END 16'hefff
`define FSP_SECT2_END 16'hdfff
`define FSP_ERASED 8'hff

// ****************************************
// Link frame
// ****************************************
`define FSP_FRAME_LAST 5'd31
`define FSP_REPLY_BITS 4'd8

`endif

// ### hw/fsp_pkg.sv
`default_nettype none
package fsp_pkg;

	// Engine states
	typedef enum logic [1:0] {
		FSP_IDLE = 2'b00,
		FSP_PROG = 2'b01,
		FSP_ERASE = 2'b10
	} fsp_state_e;

	// Operation codes carried in the first byte of a link frame
	typedef enum logic [7:0] {
		FSP_OP_PROG = 8'h01,
		FSP_OP_SERASE = 8'h02,
		FSP_OP_MERASE = 8'h03,
		FSP_OP_READ = 8'h04,
		FSP_OP_OPTION = 8'h05
	} fsp_op_e;

endpackage
`default_nettype wire

// ### hw/fsp_flash_mem.sv
`default_nettype none
module fsp_flash_mem #(
	parameter int AW = 14,
	parameter int DW = 8
) (
	// Clock
	input wire logic i_clock,
	// Write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [DW-1:0] i_wdata,
	// Read port
	input wire logic [AW-1:0] i_raddr,
	output logic [DW-1:0] o_rdata
);

	logic [DW-1:0] mem [2**AW];

	// Array write, one byte per edge
	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Registered read; a same-edge write shows one cycle later
	always_ff @(posedge i_clock) begin
		o_rdata <= mem[i_raddr];
	end

endmodule // fsp_flash_mem
`default_nettype wire

// ### hw/fsp_flash_ctrl.sv
`include "fsp_consts.svh"
`default_nettype none
module fsp_flash_ctrl import fsp_pkg::*; #(
	parameter int FLASH_BYTES = 16384,
	parameter bit MASK_ROM = 1'b0,
	parameter bit PROTECT_DEFAULT = 1'b0
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Mode strap: device sits in an off-board programming tool
	input wire logic i_tool_mode,
	// In-circuit link
	input wire logic i_prog_voltage_select,
	input wire logic i_prog_serial_clock,
	input wire logic i_prog_serial_data,
	output logic o_prog_serial_data,
	output logic o_prog_serial_data_oe,
	// Status
	output logic o_busy,
	output logic o_readout_protect
);

	localparam int AW = $clog2(FLASH_BYTES);
	localparam logic [16:0] BASE = 17'(32'h10000 - FLASH_BYTES);

	// ****************************************
	// Sector decoding
	// ****************************************

	// Present sectors follow the array size
	function automatic logic sector_ok(input logic [15:0] a);
		if (a >= `FSP_SECT0_START) return 1'b1;
		if (a >= `FSP_SECT1_START) return FLASH_BYTES >= 8192;
		return (FLASH_BYTES > 8192) && ({1'b0, a} >= BASE);
	endfunction

	function automatic logic in_sector0(input logic [15:0] a);
		return a >= `FSP_SECT0_START;
	endfunction

	// ****************************************
	// Synchronisers
	// ****************************************
	logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, sel_s1, sel_s2, tool_s1, tool_s2;

	// Pins from outside pass two flops before use
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			{clk_s1, clk_s2, clk_s3} <= 3'h0;
			{dat_s1, dat_s2, sel_s1, sel_s2, tool_s1, tool_s2} <= 6'h00;
		end else begin
			{clk_s1, clk_s2, clk_s3} <= {i_prog_serial_clock, clk_s1, clk_s2};
			{dat_s1, dat_s2} <= {i_prog_serial_data, dat_s1};
			{sel_s1, sel_s2} <= {i_prog_voltage_select, sel_s1};
			{tool_s1, tool_s2} <= {i_tool_mode, tool_s1};
		end
	end

	wire logic link_rise = clk_s2 && !clk_s3;

	// ****************************************
	// State shared by the engine and the paths
	// ****************************************
	fsp_state_e state;
	logic [15:0] cur_addr, era_end, addr_r;
	logic [7:0] prog_data, wdata_r, mem_q;
	logic era_mass, era_clr, protect, refused;
	logic go, go_erase, go_mass, go_clr, ref_link, ref_apb;
	logic [15:0] go_addr;
	logic [7:0] go_data;
	wire logic busy = state != FSP_IDLE;

	// ****************************************
	// In-circuit link receiver and replier
	// ****************************************
	logic [31:0] rx;
	logic [4:0] rx_cnt;
	logic [3:0] tx_cnt;
	logic [7:0] tx_shift;
	logic frame, rd_pend, rd_wait;
	logic [15:0] link_raddr;
	wire logic [7:0] l_op = rx[31:24];
	wire logic [15:0] l_addr = rx[23:8];
	wire logic [7:0] l_data = rx[7:0];
	wire logic rd_load = rd_pend && rd_wait;

	// Bits are taken on the tool's rising clock; frames restart when the
	// tool leaves communication mode, so a broken frame cannot linger
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !sel_s2) begin
			rx_cnt <= 5'd0;
			frame <= 1'b0;
		end else begin
			frame <= 1'b0;
			if (link_rise && tx_cnt == 4'd0) begin
				rx <= {rx[30:0], dat_s2};
				rx_cnt <= rx_cnt + 5'd1;
				frame <= rx_cnt == `FSP_FRAME_LAST;
			end
		end
	end

	// Read command: address the array, wait out its latency, then reply
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !sel_s2) begin
			rd_pend <= 1'b0;
			rd_wait <= 1'b0;
			link_raddr <= 16'h0000;
		end else if (frame && l_op == FSP_OP_READ) begin
			rd_pend <= 1'b1;
			rd_wait <= 1'b0;
			link_raddr <= l_addr;
		end else begin
			rd_wait <= rd_pend;
			if (rd_load) begin
				rd_pend <= 1'b0;
			end
		end
	end

	// Reply shifts out MSB first; the device drives data only in its turn,
	// and a protected array answers with zeros
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !sel_s2) begin
			tx_cnt <= 4'd0;
			tx_shift <= 8'h00;
		end else if (rd_load) begin
			tx_cnt <= `FSP_REPLY_BITS;
			tx_shift <= protect ? 8'h00 : mem_q;
		end else if (link_rise && tx_cnt != 4'd0) begin
			tx_cnt <= tx_cnt - 4'd1;
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	assign o_prog_serial_data = tx_shift[7];
	// Leaving communication mode releases the line at once, not a cycle late
	assign o_prog_serial_data_oe = sel_s2 && tx_cnt != 4'd0;

	// ****************************************
	// APB slave, one wait state
	// ****************************************
	logic ack;
	wire logic access = i_psel && i_penable;
	wire logic mapped = i_paddr == `FSP_OFF_CSR || i_paddr == `FSP_OFF_ADDR ||
		i_paddr == `FSP_OFF_WDATA || i_paddr == `FSP_OFF_RDATA || i_paddr == `FSP_OFF_OPT;
	wire logic wr = access && ack && i_pwrite && mapped;
	wire logic wr_csr = wr && i_paddr == `FSP_OFF_CSR;
	wire logic wr_opt = wr && i_paddr == `FSP_OFF_OPT;
	wire logic csr_cmd = wr_csr && (i_pwdata[`FSP_CSR_PROG] ||
		i_pwdata[`FSP_CSR_SERASE] || i_pwdata[`FSP_CSR_MERASE]);

	// The wait state gives array reads a full cycle after an address write
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= access && !ack;
		end
	end

	assign o_pready = access && ack;
	assign o_pslverr = access && ack && !mapped;

	// Read data captured in the first access cycle; an array read in the
	// tool socket is an external path and is blanked under protection
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0;
		end else if (access && !ack && !i_pwrite) begin
			unique case (i_paddr)
				`FSP_OFF_CSR: o_prdata <= {26'h0, protect, refused, busy, 3'h0};
				`FSP_OFF_ADDR: o_prdata <= {16'h0, addr_r};
				`FSP_OFF_WDATA: o_prdata <= {24'h0, wdata_r};
				`FSP_OFF_RDATA: o_prdata <= {24'h0, (protect && tool_s2) ? 8'h00 : mem_q};
				`FSP_OFF_OPT: o_prdata <= {31'h0, protect};
				default: o_prdata <= 32'h0;
			endcase
		end
	end

	// Address and data staging registers
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
		end else begin
			if (wr && i_paddr == `FSP_OFF_ADDR) addr_r <= i_pwdata[15:0];
			if (wr && i_paddr == `FSP_OFF_WDATA) wdata_r <= i_pwdata[7:0];
		end
	end

	// ****************************************
	// Request arbitration and permission
	// ****************************************

	// The link wins a same-cycle clash; a request while busy is refused
	always_comb begin
		go = 1'b0;
		go_erase = 1'b0;
		go_mass = 1'b0;
		go_clr = 1'b0;
		go_addr = 16'h0000;
		go_data = 8'h00;
		ref_link = 1'b0;
		ref_apb = 1'b0;
		if (frame && l_op != FSP_OP_READ) begin
			go_addr = l_addr;
			go_data = l_data;
			unique case (l_op)
				FSP_OP_PROG, FSP_OP_SERASE: begin
					go = !busy && sector_ok(l_addr);
					go_erase = l_op == FSP_OP_SERASE;
				end
				FSP_OP_MERASE: begin
					go = !busy;
					go_mass = 1'b1;
				end
				FSP_OP_OPTION: begin
					go = !busy && !MASK_ROM && protect && !l_data[0];
					go_mass = 1'b1;
					go_clr = 1'b1;
				end
				default: go = 1'b0;
			endcase
			go_erase = go_erase || go_mass;
			ref_link = !go && !(l_op == FSP_OP_OPTION && !busy && !MASK_ROM);
			ref_apb = csr_cmd || wr_opt;
		end else if (csr_cmd) begin
			go_addr = addr_r;
			go_data = wdata_r;
			go_mass = i_pwdata[`FSP_CSR_MERASE];
			go_erase = i_pwdata[`FSP_CSR_SERASE] || go_mass;
			// Outside the tool socket sector 0 and the whole array are locked
			if (go_mass) go = !busy && tool_s2;
			else go = !busy && sector_ok(addr_r) && (tool_s2 || !in_sector0(addr_r));
			ref_apb = !go;
		end else if (wr_opt) begin
			go_addr = addr_r;
			go = !busy && tool_s2 && !MASK_ROM && protect && !i_pwdata[0];
			go_erase = 1'b1;
			go_mass = 1'b1;
			go_clr = 1'b1;
			ref_apb = busy || !tool_s2 || MASK_ROM;
		end
	end

	// ****************************************
	// Program/erase engine
	// ****************************************

	// One byte per program; erase walks its range writing the erased value
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state <= FSP_IDLE;
			cur_addr <= 16'h0000;
			era_end <= 16'h0000;
			prog_data <= 8'h00;
			era_mass <= 1'b0;
			era_clr <= 1'b0;
		end else begin
			unique case (state)
				FSP_IDLE: if (go) begin
					era_mass <= go_mass;
					era_clr <= go_clr;
					prog_data <= go_data;
					if (!go_erase) begin
						state <= FSP_PROG;
						cur_addr <= go_addr;
					end else begin
						state <= FSP_ERASE;
						// Range stays inside one sector, except a mass erase, which runs from the array base to FFFFh
						if (go_mass) begin
							cur_addr <= BASE[15:0];
							era_end <= `FSP_SECT0_END;
						end else if (in_sector0(go_addr)) begin
							cur_addr <= `FSP_SECT0_START;
							era_end <= `FSP_SECT0_END;
						end else if (go_addr >= `FSP_SECT1_START) begin
							cur_addr <= `FSP_SECT1_START;
							era_end <= `FSP_SECT1_END;
						end else begin
							cur_addr <= BASE[15:0];
							era_end <= `FSP_SECT2_END;
						end
					end
				end
				FSP_PROG: state <= FSP_IDLE;
				FSP_ERASE: begin
					if (cur_addr == era_end) state <= FSP_IDLE;
					else cur_addr <= cur_addr + 16'h0001;
				end
				default: state <= FSP_IDLE;
			endcase
		end
	end

	// Protection leaves only after the forced full erase has ended
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			protect <= PROTECT_DEFAULT;
		end else if (!MASK_ROM) begin
			if (state == FSP_ERASE && era_clr && cur_addr == era_end) protect <= 1'b0;
			else if (!busy && frame && l_op == FSP_OP_OPTION && l_data[0]) protect <= 1'b1;
			else if (!busy && !frame && wr_opt && tool_s2 && i_pwdata[0]) protect <= 1'b1;
		end
	end

	// Sticky refusal flag; a new refusal beats a clear in the same cycle
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			refused <= 1'b0;
		end else if (ref_link || ref_apb) begin
			refused <= 1'b1;
		end else if (wr_csr && i_pwdata[`FSP_CSR_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	// ****************************************
	// Array
	// ****************************************
	wire logic mem_we = state == FSP_PROG || state == FSP_ERASE;
	wire logic [7:0] mem_wdata = state == FSP_PROG ? prog_data : `FSP_ERASED;

	fsp_flash_mem #(.AW(AW), .DW(8)) u_mem (
		.i_clock(i_clock),
		.i_we(mem_we),
		.i_waddr(cur_addr[AW-1:0]),
		.i_wdata(mem_wdata),
		.i_raddr(rd_pend ? link_raddr[AW-1:0] : addr_r[AW-1:0]),
		.o_rdata(mem_q)
	);

	assign o_busy = busy;
	assign o_readout_protect = protect;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_prog_one_byte: assert property (state == FSP_PROG |=> state == FSP_IDLE)
		else $error("program lasted more than one byte");
	a_erase_value: assert property (state == FSP_ERASE |-> mem_we && mem_wdata == 8'hff)
		else $error("erase wrote a value other than erased");
	a_erase_range: assert property (state == FSP_ERASE && !era_mass |->
		cur_addr[15:12] == era_end[15:12] || era_end == 16'hdfff)
		else $error("sector erase left its sector");
	a_icp_sector0: assert property (frame && sel_s2 && !busy && l_op == FSP_OP_PROG &&
		in_sector0(l_addr) |=> state == FSP_PROG && cur_addr == $past(l_addr))
		else $error("in-circuit program of sector 0 not done");
	a_iap_lock: assert property (csr_cmd && !frame && !tool_s2 && in_sector0(addr_r)
		|=> state == FSP_IDLE ##0 refused)
		else $error("in-application change of sector 0 accepted");
	a_absent_sect: assert property (state == FSP_PROG |-> sector_ok(cur_addr))
		else $error("write to an absent sector");
	a_sect0_top: assert property (state == FSP_ERASE && !era_mass && cur_addr >= 16'hf000
		|-> era_end == 16'hffff)
		else $error("sector 0 range wrong");
	a_unprot_erase: assert property ($fell(protect) |-> $past(state) == FSP_ERASE &&
		$past(era_mass) && $past(cur_addr) == 16'hffff)
		else $error("protection removed without full erase");
	a_reply_blank: assert property (rd_load && protect |=> tx_shift == 8'h00 [*2])
		else $error("protected contents sent on the link");
	a_mask_fixed: assert property (MASK_ROM |-> protect == PROTECT_DEFAULT)
		else $error("mask part protection changed");
	a_data_turn: assert property ($rose(o_prog_serial_data_oe) |-> $past(rd_load))
		else $error("data driven outside the device turn");
	a_csr_reset: assert property (@(posedge i_clock) !i_rst_n |=> !refused && !busy)
		else $error("control/status not cleared by reset");

	c_prog: cover property (state == FSP_PROG);
	c_sect_erase: cover property (state == FSP_ERASE && !era_mass && cur_addr == era_end);
	c_unprotect: cover property ($fell(protect));
	c_link_read: cover property (rd_load ##1 o_prog_serial_data_oe);

endmodule // fsp_flash_ctrl
`default_nettype wire

// ### tb/fsp_tool_model.sv
`default_nettype none
module fsp_tool_model (
	// Lines toward the device: clock, data, mode select
	output var logic o_sclk,
	output var logic o_sdata,
	output var logic o_sdata_oe,
	output var logic o_vsel,
	// Resolved level of the shared data line
	input wire logic i_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clock idles low outside frames, data released
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_sdata_oe = 1'b0;
		o_vsel = 1'b0;
	end

	// Mode must be raised before any frame is sent
	task automatic enter();
		o_vsel = 1'b1;
		#100;
	endtask

	// Frame goes out MSB first; data set while clock is low
	task automatic send(input logic [31:0] f);
		// Step off the system clock edge so no pin moves as it is sampled
		#1;
		for (int i = 31; i >= 0; i--) begin
			o_sdata_oe = 1'b1;
			o_sdata = f[i];
			#24 o_sclk = 1'b1;
			#24 o_sclk = 1'b0;
		end
		o_sdata_oe = 1'b0; // Hand the line over to the device
	endtask

	// Reply is sampled on our own rising edges, eight of them
	task automatic recv(output logic [7:0] r);
		#60;
		for (int i = 7; i >= 0; i--) begin
			#24 o_sclk = 1'b1;
			r[i] = i_line;
			#24 o_sclk = 1'b0;
		end
		#60;
	endtask

	// Dropping the mode line ends communication mode and any frame in flight
	task automatic leave();
		o_vsel = 1'b0;
		#100;
	endtask
endmodule // fsp_tool_model
`default_nettype wire

// ### tb/flash_sector_protection_tb.sv
`include "fsp_consts.svh"
`default_nettype none
module flash_sector_protection_tb import fsp_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// Stimulus, wires and bookkeeping
	// ****************************************
	logic i_clock = 1'b0, i_rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic tmode = 1'b1, idle = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwd = 32'h0;
	wire logic [31:0] prd, prd_s;
	wire logic prdy, perr, sd, soe, busy, prot, tclk, tsd, toe, vsel, line;
	int miscompares = 0, checked = 0;
	logic [33:0] exp_q[$];
	logic [7:0] b0, b1, b2, r;

	// Clock and a released-line pattern that changes every cycle
	always #2 i_clock = ~i_clock;
	always @(posedge i_clock) idle <= ~idle;
	assign line = soe ? sd : (toe ? tsd : idle);

	fsp_flash_ctrl dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(perr), .i_tool_mode(tmode), .i_prog_voltage_select(vsel),
		.i_prog_serial_clock(tclk), .i_prog_serial_data(line), .o_prog_serial_data(sd),
		.o_prog_serial_data_oe(soe), .o_busy(busy), .o_readout_protect(prot));
	// Smaller part on the same bus, only its read data is looked at
	fsp_flash_ctrl #(.FLASH_BYTES(8192)) dut_s (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
		.o_prdata(prd_s), .o_pready(), .o_pslverr(), .i_tool_mode(tmode),
		.i_prog_voltage_select(vsel), .i_prog_serial_clock(tclk), .i_prog_serial_data(line),
		.o_prog_serial_data(), .o_prog_serial_data_oe(), .o_busy(), .o_readout_protect());
	fsp_tool_model tool (.o_sclk(tclk), .o_sdata(tsd), .o_sdata_oe(toe), .o_vsel(vsel),
		.i_line(line));

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk(logic [33:0] seen, logic [33:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Answer taken at the rising edge that samples pready high
	always @(posedge i_clock) if (psel && pen && prdy === 1'b1) begin
		logic [33:0] e;
		e = exp_q.pop_front();
		chk({e[33], perr, (e[33] && !e[32]) ? prd : 32'h0}, e);
	end

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e = 0,
		logic er = 0);
		int n = 0;
		exp_q.push_back({!w, er, (w || er) ? 32'h0 : e});
		@(posedge i_clock);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge i_clock);
		pen <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e, logic er = 0);
		apb(1'b0, a, 32'h0, e, er);
	endtask
	// Bounded wait for the engine to finish
	task automatic idle_wait();
		int n = 0;
		repeat (3) @(posedge i_clock);
		while (busy === 1'b1 && n < 20000) begin
			@(posedge i_clock);
			n++;
		end
		if (n >= 20000) miscompares++;
	endtask
	task automatic cmd(logic [15:0] a, logic [31:0] bits);
		wr(`FSP_OFF_ADDR, {16'h0, a});
		wr(`FSP_OFF_CSR, bits);
		idle_wait();
	endtask
	task automatic prog(logic [15:0] a, logic [7:0] d);
		wr(`FSP_OFF_WDATA, {24'h0, d});
		cmd(a, 32'h1);
	endtask
	task automatic rb(logic [15:0] a, logic [7:0] e);
		wr(`FSP_OFF_ADDR, {16'h0, a});
		rd(`FSP_OFF_RDATA, {24'h0, e});
	endtask
	task automatic lnk(logic [7:0] op, logic [15:0] a, logic [7:0] d);
		tool.send({op, a, d});
		idle_wait();
	endtask
	task automatic lrd(logic [15:0] a, logic [7:0] e);
		tool.send({FSP_OP_READ, a, 8'h00});
		tool.recv(r);
		chk(34'(r), 34'(e));
	endtask
	task automatic mode(logic m);
		tmode <= m;
		repeat (4) @(posedge i_clock);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(32'h5a7f7a39));
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		b2 = 8'($urandom);
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		rd(`FSP_OFF_CSR, 32'h0);
		rd(`FSP_OFF_OPT, 32'h0);
		rd(12'h100, 32'h0, 1'b1);
		$display("Reset values done");
		cmd(16'h0000, 32'h4);
		prog(16'hf000, b0);
		prog(16'he000, b1);
		rb(16'hf000, b0);
		rb(16'he000, b1);
		rb(16'hd000, 8'hff);
		$display("Tool mode done");
		mode(1'b0);
		prog(16'hf001, 8'h12);
		rd(`FSP_OFF_CSR, 32'h10);
		wr(`FSP_OFF_CSR, 32'h10);
		cmd(16'h0000, 32'h4);
		rd(`FSP_OFF_CSR, 32'h10);
		wr(`FSP_OFF_CSR, 32'h10);
		rb(16'hf001, 8'hff);
		prog(16'he001, b2);
		rb(16'he001, b2);
		cmd(16'he800, 32'h2);
		rb(16'he001, 8'hff);
		rb(16'hf000, b0);
		$display("Application mode done");
		mode(1'b1);
		cmd(16'hd000, 32'h2);
		rd(`FSP_OFF_CSR, 32'h0);
		chk(34'(prd_s), 34'h10);
		wr(`FSP_OFF_CSR, 32'h10);
		$display("Flash size done");
		tool.enter();
		lnk(FSP_OP_PROG, 16'he123, b2);
		lrd(16'he123, b2);
		lrd(16'hf000, b0);
		lnk(FSP_OP_SERASE, 16'hf000, 8'h00);
		lrd(16'hf000, 8'hff);
		lnk(FSP_OP_PROG, 16'hf000, b1);
		lrd(16'hf000, b1);
		$display("Link done");
		wr(`FSP_OFF_OPT, 32'h1);
		rd(`FSP_OFF_CSR, 32'h20);
		chk(34'(prot), 34'h1);
		rb(16'he123, 8'h00);
		lrd(16'he123, 8'h00);
		wr(`FSP_OFF_OPT, 32'h0);
		rd(`FSP_OFF_CSR, 32'h28);
		chk(34'(busy), 34'h1);
		idle_wait();
		chk(34'(prot), 34'h0);
		rb(16'he123, 8'hff);
		rb(16'hf000, 8'hff);
		tool.leave();
		$display("Protection done");
		complete_run();
	end

	// Watchdog well beyond the sum of all erases, still under the cycle budget
	initial begin
		#320000;
		miscompares++;
		complete_run();
	end
endmodule // flash_sector_protection_tb
`default_nettype wire
